// ### core/acps_mux.sv
// Purpose: per-pin function multiplexer for the auxiliary configurable pins
// Assumes: function selectors loaded from configuration memory over Wishbone
// Notes:   usb and uart status come from logic on the same clock

module acps_mux import acps_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire acps_usb_s usb_in,
  input wire acps_uart_s uart_in,
  output logic tx_start_ok_out,
  input wire logic [PIN_COUNT-1:0] aux_config_pins_in,
  output logic [PIN_COUNT-1:0] aux_config_pins_out,
  output logic [PIN_COUNT-1:0] aux_config_pins_oe_out,
  output logic [PIN_COUNT-1:0] pull_up_out,
  output logic [PIN_COUNT-1:0] pull_down_out
);

  // ***********************************
  // function availability
  // ***********************************
  function automatic logic fn_offered(input int pin, input logic [SEL_W-1:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      FN_INPUT_WITH_PULLUP: ok = 1'b1;
      FN_LINE_DRIVER_ENABLE, FN_POWER_ENABLE_N, FN_TRANSMIT_LED_N, FN_RECEIVE_LED_N,
      FN_ACTIVITY_LED_N, FN_SLEEP_N, FN_DRIVE_LOW: ok = PINS_COMMON[pin];
      FN_CLOCK_OUT_FAST, FN_CLOCK_OUT_HALF, FN_CLOCK_OUT_QUARTER,
      FN_DRIVE_HIGH: ok = PINS_CLOCK[pin];
      FN_BIT_BANG: ok = PINS_BIT_BANG[pin];
      FN_INPUT_WITH_PULLDOWN: ok = PINS_PULLDOWN[pin];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ***********************************
  // registers
  // ***********************************
  logic [PIN_COUNT*SEL_W-1:0] sel_r;
  logic pd_suspend_r;
  logic [PIN_COUNT-1:0] bb_data_r;
  logic [PIN_COUNT-1:0] bb_dir_r;
  logic [PIN_COUNT-1:0] pin_level;
  logic drv_en_r;
  logic wb_req;
  logic [31:0] wmask;

  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  acps_sync3 #(.W(PIN_COUNT)) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .d_in(aux_config_pins_in),
    .q_out(pin_level)
  );

  // one wait state: ack one edge after the request is seen
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req;
    end
  end

  // selectors change only from the configuration loader, never from the data path
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        sel_r[i*SEL_W +: SEL_W] <= (i == PIN_PULLDOWN_DEFAULT) ?
          FN_INPUT_WITH_PULLDOWN : FN_INPUT_WITH_PULLUP;
      end
      pd_suspend_r <= 1'b0;
    end else if (wb_req && wb_we_in) begin
      if (wb_adr_in == REG_SEL_LO) begin
        sel_r[31:0] <= (sel_r[31:0] & ~wmask) | (wb_dat_in & wmask);
      end else if (wb_adr_in == REG_SEL_HI) begin
        if (wb_sel_in[0]) begin
          sel_r[PIN_COUNT*SEL_W-1:32] <= wb_dat_in[SEL_HI_PINS*SEL_W-1:0];
        end
        if (wb_sel_in[1]) begin
          pd_suspend_r <= wb_dat_in[POS_PD_SUSPEND];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bb_data_r <= '0;
      bb_dir_r <= '0;
    end else if (wb_req && wb_we_in) begin
      if (wb_adr_in == REG_BB_DATA) begin
        bb_data_r <= (bb_data_r & ~wmask[PIN_COUNT-1:0]) | (wb_dat_in[PIN_COUNT-1:0] &
          wmask[PIN_COUNT-1:0]);
      end else if (wb_adr_in == REG_BB_DIR) begin
        bb_dir_r <= (bb_dir_r & ~wmask[PIN_COUNT-1:0]) | (wb_dat_in[PIN_COUNT-1:0] &
          wmask[PIN_COUNT-1:0]);
      end
    end
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wb_dat_out <= '0;
    end else if (wb_req && !wb_we_in) begin
      wb_dat_out <= '0;
      case (wb_adr_in)
        REG_SEL_LO: wb_dat_out <= sel_r[31:0];
        REG_SEL_HI: begin
          wb_dat_out[SEL_HI_PINS*SEL_W-1:0] <= sel_r[PIN_COUNT*SEL_W-1:32];
          wb_dat_out[POS_PD_SUSPEND] <= pd_suspend_r;
        end
        REG_BB_DATA: wb_dat_out[PIN_COUNT-1:0] <= bb_data_r;
        REG_BB_DIR: wb_dat_out[PIN_COUNT-1:0] <= bb_dir_r;
        REG_STATUS: begin
          wb_dat_out[PIN_COUNT-1:0] <= pin_level;
          wb_dat_out[POS_ST_SUSPEND] <= usb_in.suspend;
          wb_dat_out[POS_ST_CONFIGURED] <= usb_in.configured;
          wb_dat_out[POS_ST_DRV_EN] <= drv_en_r;
        end
        default: wb_dat_out <= '0;
      endcase
    end
  end

  // ***********************************
  // line driver enable sequencer
  // ***********************************
  // the uart waits for tx_start_ok_out, so the lead bit is guaranteed here
  acps_de_e de_state_r;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      de_state_r <= DE_IDLE;
    end else begin
      case (de_state_r)
        DE_IDLE: if (uart_in.tx_request) de_state_r <= DE_LEAD;
        DE_LEAD: if (uart_in.bit_tick) de_state_r <= DE_SEND;
        DE_SEND: if (!uart_in.tx_request && !uart_in.tx_busy) de_state_r <= DE_TAIL;
        DE_TAIL: begin
          // a new frame waits for a fresh bit boundary before permission returns
          if (uart_in.tx_request) begin
            de_state_r <= DE_LEAD;
          end else if (uart_in.bit_tick) begin
            de_state_r <= DE_IDLE;
          end
        end
        default: de_state_r <= DE_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      drv_en_r <= 1'b0;
      tx_start_ok_out <= 1'b0;
    end else begin
      drv_en_r <= (de_state_r != DE_IDLE) || uart_in.tx_request;
      // permission ends with the frame, never one cycle into the tail
      tx_start_ok_out <= (de_state_r == DE_SEND && (uart_in.tx_request || uart_in.tx_busy)) ||
        (de_state_r == DE_LEAD && uart_in.bit_tick);
    end
  end

  // ***********************************
  // clock outputs
  // ***********************************
  // 30 MHz is not an integer divide of 200 MHz: edges land on the next
  // system edge, so period jitter of one system cycle is traded for accuracy
  logic [8:0] clk_acc_r;
  logic clk_fast_r;
  logic clk_half_r;
  logic clk_quarter_r;
  logic [8:0] clk_acc_sum;

  assign clk_acc_sum = clk_acc_r + CLK_ACC_STEP;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || usb_in.suspend) begin
      clk_acc_r <= '0;
      clk_fast_r <= 1'b0;
      clk_half_r <= 1'b0;
      clk_quarter_r <= 1'b0;
    end else if (clk_acc_sum >= CLK_ACC_WRAP) begin
      clk_acc_r <= clk_acc_sum - CLK_ACC_WRAP;
      clk_fast_r <= ~clk_fast_r;
      if (!clk_fast_r) begin
        clk_half_r <= ~clk_half_r;
        if (!clk_half_r) begin
          clk_quarter_r <= ~clk_quarter_r;
        end
      end
    end else begin
      clk_acc_r <= clk_acc_sum;
    end
  end

  // ***********************************
  // per-pin function decode
  // ***********************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aux_config_pins_out <= '0;
      aux_config_pins_oe_out <= '0;
      pull_up_out <= ~PINS_PULLDOWN;
      pull_down_out <= PINS_PULLDOWN;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        logic [SEL_W-1:0] code;
        logic o;
        logic oe;
        code = sel_r[i*SEL_W +: SEL_W];
        o = 1'b0;
        oe = 1'b1;
        if (!fn_offered(i, code)) begin
          code = FN_INPUT_WITH_PULLUP;
        end
        case (code)
          FN_LINE_DRIVER_ENABLE: o = drv_en_r;
          FN_POWER_ENABLE_N: o = ~usb_in.configured | usb_in.suspend;
          FN_TRANSMIT_LED_N: o = ~uart_in.tx_busy;
          FN_RECEIVE_LED_N: o = ~uart_in.rx_busy;
          FN_ACTIVITY_LED_N: o = ~(uart_in.tx_busy | uart_in.rx_busy);
          FN_SLEEP_N: o = ~usb_in.suspend;
          FN_CLOCK_OUT_FAST: o = clk_fast_r;
          FN_CLOCK_OUT_HALF: o = clk_half_r;
          FN_CLOCK_OUT_QUARTER: o = clk_quarter_r;
          FN_DRIVE_HIGH: o = 1'b1;
          FN_DRIVE_LOW: o = 1'b0;
          FN_BIT_BANG: begin
            o = bb_data_r[i];
            oe = bb_dir_r[i];
          end
          default: oe = 1'b0;
        endcase
        aux_config_pins_out[i] <= o;
        aux_config_pins_oe_out[i] <= oe;
        // pull-down on suspend option overrides input pull-ups
        if (oe) begin
          pull_up_out[i] <= 1'b0;
          pull_down_out[i] <= 1'b0;
        end else if ((pd_suspend_r && usb_in.suspend) || code == FN_INPUT_WITH_PULLDOWN) begin
          pull_up_out[i] <= 1'b0;
          pull_down_out[i] <= 1'b1;
        end else begin
          pull_up_out[i] <= 1'b1;
          pull_down_out[i] <= 1'b0;
        end
      end
    end
  end

endmodule

// ### core/acps_pkg.sv
// Purpose: shared constants and types for the auxiliary pin function select block
// Assumes: 200 MHz system clock, classic Wishbone register access, 10 auxiliary pins
// Notes:   function codes and register offsets are fixed here and used everywhere
package acps_pkg;

  // ***********************************
  // sizes and clocks
  // ***********************************
  localparam int PIN_COUNT = 10;
  localparam int SEL_W = 4;
  localparam int SYS_CLK_MHZ = 200;
  localparam int CLK_FAST_MHZ = 30;
  // two toggles per output period
  localparam logic [8:0] CLK_ACC_STEP = 9'(2 * CLK_FAST_MHZ);
  localparam logic [8:0] CLK_ACC_WRAP = 9'(SYS_CLK_MHZ);

  // ***********************************
  // register map (byte addresses)
  // ***********************************
  localparam logic [7:0] REG_SEL_LO = 8'h00;
  localparam logic [7:0] REG_SEL_HI = 8'h04;
  localparam logic [7:0] REG_BB_DATA = 8'h08;
  localparam logic [7:0] REG_BB_DIR = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int SEL_HI_PINS = 2;
  localparam int POS_PD_SUSPEND = 8;
  localparam int POS_ST_SUSPEND = 16;
  localparam int POS_ST_CONFIGURED = 17;
  localparam int POS_ST_DRV_EN = 18;
  localparam int PIN_PULLDOWN_DEFAULT = 7;

  // ***********************************
  // pin function codes
  // ***********************************
  typedef enum logic [SEL_W-1:0] {
    FN_INPUT_WITH_PULLUP = 4'h0,
    FN_LINE_DRIVER_ENABLE = 4'h1,
    FN_POWER_ENABLE_N = 4'h2,
    FN_TRANSMIT_LED_N = 4'h3,
    FN_RECEIVE_LED_N = 4'h4,
    FN_ACTIVITY_LED_N = 4'h5,
    FN_SLEEP_N = 4'h6,
    FN_CLOCK_OUT_FAST = 4'h7,
    FN_CLOCK_OUT_HALF = 4'h8,
    FN_CLOCK_OUT_QUARTER = 4'h9,
    FN_DRIVE_HIGH = 4'hA,
    FN_DRIVE_LOW = 4'hB,
    FN_BIT_BANG = 4'hC,
    FN_INPUT_WITH_PULLDOWN = 4'hD
  } acps_fn_e;

  // pins offering the common functions, clock/drive-high, and bit-bang
  localparam logic [PIN_COUNT-1:0] PINS_COMMON = 10'h37F;
  localparam logic [PIN_COUNT-1:0] PINS_CLOCK = 10'h361;
  localparam logic [PIN_COUNT-1:0] PINS_BIT_BANG = 10'h360;
  localparam logic [PIN_COUNT-1:0] PINS_PULLDOWN = 10'h080;

  // ***********************************
  // carriers
  // ***********************************
  typedef struct packed {
    logic configured;
    logic suspend;
  } acps_usb_s;

  typedef struct packed {
    logic tx_request;
    logic tx_busy;
    logic rx_busy;
    logic bit_tick;
  } acps_uart_s;

  typedef enum logic [3:0] {
    DE_IDLE = 4'b0001,
    DE_LEAD = 4'b0010,
    DE_SEND = 4'b0100,
    DE_TAIL = 4'b1000
  } acps_de_e;

endpackage

// ### core/acps_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to sys_clk_in
// Notes:   output follows only when stages two and three agree
module acps_sync3 #(
  parameter int W = 10
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // hold on disagreement: a single-cycle glitch never reaches q_out
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q_out <= '0;
    end else begin
      q_out <= (s2_r & s3_r) | (q_out & (s2_r ^ s3_r));
    end
  end

endmodule

// ### dv/acps_ext_logic.sv
// Purpose: external logic at the auxiliary pins: pulls, loads and drivers
// Assumes: a design driver wins over an external one
// Notes: a pin with neither drive nor pull reads back inverted
module acps_ext_logic import acps_pkg::*; (
  input wire logic [PIN_COUNT-1:0] pins_in,
  input wire logic [PIN_COUNT-1:0] oe_in,
  input wire logic [PIN_COUNT-1:0] pull_up_in,
  input wire logic [PIN_COUNT-1:0] pull_down_in,
  input wire logic [PIN_COUNT-1:0] ext_en_in,
  input wire logic [PIN_COUNT-1:0] ext_val_in,
  output logic [PIN_COUNT-1:0] level_out
);
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (oe_in[i] === 1'h1) level_out[i] = pins_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pull_down_in[i] === 1'h1) level_out[i] = 1'h0;
      else if (pull_up_in[i] === 1'h1) level_out[i] = 1'h1;
      else level_out[i] = ~pins_in[i];
    end
  end
endmodule

// ### dv/acps_mux_checker.sv
// Purpose: port assertions for the auxiliary pin multiplexer
// Assumes: one clock, synchronous active-high reset
// Notes: clock frequencies are judged by the bench, not here
module acps_mux_checker import acps_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire acps_usb_s usb_in,
  input wire acps_uart_s uart_in,
  input wire logic tx_start_ok_out,
  input wire logic [PIN_COUNT-1:0] aux_config_pins_in,
  input wire logic [PIN_COUNT-1:0] aux_config_pins_out,
  input wire logic [PIN_COUNT-1:0] aux_config_pins_oe_out,
  input wire logic [PIN_COUNT-1:0] pull_up_out,
  input wire logic [PIN_COUNT-1:0] pull_down_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_reset_pulls: assert property (disable iff (1'h0) rst_in |=> pull_up_out == 10'h37F && pull_down_out == 10'h080 && aux_config_pins_oe_out == 10'h000)
    else $error("pin defaults wrong after reset");
  a_drive_no_pull: assert property (((pull_up_out | pull_down_out) & aux_config_pins_oe_out) == 10'h000 && (pull_up_out & pull_down_out) == 10'h000)
    else $error("pull active on a driven pin");
  a_pin_seven_input: assert property (!aux_config_pins_oe_out[7])
    else $error("pin seven driven");
  a_pulldown_cause: assert property (|(pull_down_out & 10'h37F) |-> $past(usb_in.suspend))
    else $error("pull-down outside suspend");
  a_ok_after_tick: assert property ($rose(tx_start_ok_out) |-> $past(uart_in.bit_tick))
    else $error("start permission not on a bit boundary");
  a_busy_needs_ok: assert property ($rose(uart_in.tx_busy) |-> tx_start_ok_out)
    else $error("frame began without permission");
  a_ok_drops_idle: assert property ($fell(tx_start_ok_out) |-> !uart_in.tx_busy && $past(!uart_in.tx_busy && !uart_in.tx_request))
    else $error("permission dropped while sending");
endmodule
bind acps_mux acps_mux_checker acps_mux_checker_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .usb_in(usb_in), .uart_in(uart_in), .tx_start_ok_out(tx_start_ok_out),
  .aux_config_pins_in(aux_config_pins_in), .aux_config_pins_out(aux_config_pins_out),
  .aux_config_pins_oe_out(aux_config_pins_oe_out), .pull_up_out(pull_up_out),
  .pull_down_out(pull_down_out));

// ### dv/acps_mux_bench.sv
// Purpose: self-checking bench for acps_mux
// Assumes: bench plays the uart and usb state; pins see acps_ext_logic
// Notes: bit time shortened to BIT cycles to keep frames brief
module acps_mux_bench import acps_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = 8;
  logic sys_clk_in = 1'h0, rst_in = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, ok;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0, rdat, q, lo, hi, dir, bbd;
  acps_usb_s usb = 2'h2;
  acps_uart_s uart = 4'h0;
  logic [9:0] lvl, pout, poe, pu, pd, ext_en = 10'h3FF, ext_val = 10'h0;
  logic [4:0] e;
  int err_count = 0, check_count = 0, tick_cnt = 0, en_cnt = 0, r[3], cp[3] = '{0, 5, 6};
  acps_mux acps_mux_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .usb_in(usb), .uart_in(uart), .tx_start_ok_out(ok),
    .aux_config_pins_in(lvl), .aux_config_pins_out(pout), .aux_config_pins_oe_out(poe),
    .pull_up_out(pu), .pull_down_out(pd));
  acps_ext_logic acps_ext_logic_inst (.pins_in(pout), .oe_in(poe), .pull_up_in(pu),
    .pull_down_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    tick_cnt <= (tick_cnt == BIT - 1) ? 0 : tick_cnt + 1;
    uart.bit_tick <= (tick_cnt == BIT - 1);
    en_cnt <= (pout[1] === 1'h1) ? en_cnt + 1 : 0;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'h1);
    chk("ack_latency", 32'h2, n);
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic wait_edges(input int n, input logic on_tick);
    repeat (n) do @(posedge sys_clk_in); while (on_tick && uart.bit_tick !== 1'h1);
  endtask
  // drive enable must wrap the frame by a bit time each side
  task automatic frame(input logic rx);
    int n;
    {uart.tx_request, uart.rx_busy} <= {1'h1, rx};
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (!(uart.bit_tick === 1'h1 && ok === 1'h1) && n < 200);
    chk("lead", 1'h1, ok === 1'h1 && en_cnt + 1 >= BIT);
    {uart.tx_busy, uart.tx_request} <= 2'h2;
    wait_edges(5, 1'h1);
    chk("leds", {1'h1, 1'h0, ~rx, 1'h0}, {pout[1], pout[3], pout[4], pout[5]});
    wait_edges(5, 1'h1);
    {uart.tx_busy, uart.rx_busy} <= 2'h0;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pout[1] !== 1'h0 && n < 100);
    chk("tail", 1'h1, n > BIT && n <= 2 * BIT + 4);
    chk("leds_idle", 3'h7, {pout[3], pout[4], pout[5]});
  endtask
  task automatic count_rises(input int n);
    logic [9:0] prev;
    r = '{0, 0, 0};
    @(posedge sys_clk_in);
    prev = pout;
    repeat (n) begin
      @(posedge sys_clk_in);
      foreach (r[k]) r[k] += int'(pout[cp[k]] & ~prev[cp[k]]);
      prev = pout;
    end
  endtask
  // returns drive, value known, value, pull-up, pull-down
  function automatic logic [4:0] exp_pin(int p, logic [3:0] c, logic d, logic v, logic pds);
    logic ck, drv, val, dn;
    ck = p inside {0, 5, 6, 8, 9};
    if (!(c == 4'h0 || (c inside {[4'h1:4'h6], 4'hB} && p != 7) || (c inside {[4'h7:4'hA]} && ck)
        || (c == 4'hC && ck && p != 0) || (c == 4'hD && p == 7))) c = 4'h0;
    drv = c inside {[4'h1:4'hB]} || (c == 4'hC && d);
    case (c)
      4'h2: val = ~usb.configured | usb.suspend;
      4'h3, 4'hA: val = 1'h1;
      4'h4, 4'h5: val = ~uart.rx_busy;
      4'h6: val = ~usb.suspend;
      4'hC: val = v;
      default: val = 1'h0;
    endcase
    dn = !drv && (c == 4'hD || (pds && usb.suspend));
    return {drv, !(c inside {[4'h7:4'h9]}) || usb.suspend, val, !drv && !dn, dn};
  endfunction
  initial begin
    lo = $urandom(32'h525D);
    ext_val = lo[9:0];
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    chk("pulls", {10'h37F, 10'h080}, {pu, pd});
    // synchroniser stages restart from zero at release
    wait_edges(4, 1'h0);
    wb_cycle(1'h0, REG_STATUS, 32'h0);
    chk("status", {14'h0, usb.configured, usb.suspend, 6'h0, ext_val}, q);
    ext_en <= 10'h000;
    wb_cycle(1'h1, REG_STATUS, 32'hFFFF_FFFF);
    wb_cycle(1'h0, REG_STATUS, 32'h0);
    chk("pulled_levels", 32'h0002_037F, q);
    wb_cycle(1'h0, REG_SEL_LO, 32'h0);
    chk("sel_default", 32'hD000_0000, q);
    wb_cycle(1'h0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    sel <= 4'h1;
    wb_cycle(1'h1, REG_SEL_LO, 32'hFFFF_FF21);
    sel <= 4'hF;
    wb_cycle(1'h0, REG_SEL_LO, 32'h0);
    chk("sel_byte_lane", 32'hD000_0021, q);
    repeat (24) begin
      {lo, hi, dir, bbd} = {$urandom, $urandom, $urandom, $urandom};
      usb <= acps_usb_s'(2'($urandom));
      uart.rx_busy <= 1'($urandom);
      wb_cycle(1'h1, REG_SEL_LO, lo);
      wb_cycle(1'h1, REG_SEL_HI, hi);
      wb_cycle(1'h1, REG_BB_DATA, bbd);
      wb_cycle(1'h1, REG_BB_DIR, dir);
      wait_edges(3, 1'h0);
      for (int p = 0; p < 10; p++) begin
        e = exp_pin(p, (p < 8) ? lo[4*p +: 4] : hi[4*p-32 +: 4], dir[p], bbd[p], hi[8]);
        chk("drive", e[4], poe[p]);
        if (e[4] && e[3]) chk("level", e[2], pout[p]);
        chk("pull", e[1:0], {pu[p], pd[p]});
      end
    end
    {usb, uart.rx_busy} <= 3'h4;
    wb_cycle(1'h1, REG_SEL_LO, 32'hD054_3010);
    wb_cycle(1'h1, REG_SEL_HI, 32'h0);
    wait_edges(4, 1'h0);
    frame(1'h0);
    frame(1'h1);
    wb_cycle(1'h1, REG_SEL_LO, 32'hD980_0007);
    count_rises(400);
    chk("clk_rates", 3'h7, {r[0] inside {[59:61]}, r[1] inside {[29:31]}, r[2] inside {[14:16]}});
    usb <= 2'h3;
    wait_edges(3, 1'h0);
    count_rises(100);
    chk("clk_suspended", 0, r[0] + r[1] + r[2] + 32'(pout[0]));
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    complete_run();
  end
endmodule
